// ==== exec_core.sv ====
// instruction execute unit with wishbone register access
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module exec_core
    import exec_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wake_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             sleep_o,
    output logic             timeout_o
);
    typedef enum logic [1:0] {ST_RUN, ST_CALL2, ST_SLEEP} state_t;
    typedef enum logic [1:0] {HALF_NONE, HALF_FIRST, HALF_SECOND} half_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t                  state_reg;
    half_t                   half_reg;
    logic [7:0]              acc_reg;
    logic                    z_reg;
    logic                    c_reg;
    logic                    ac_reg;
    logic                    to_reg;
    logic                    sleep_reg;
    logic [PC_W-1:0]         pc_reg;
    logic [PC_W-1:0]         tgt_reg;
    logic [SP_W-1:0]         sp_reg;
    logic [PC_W-1:0]         stack_reg [STACK_DEPTH];
    logic [7:0]              mem_reg   [MEM_DEPTH];
    logic [WDT_W-1:0]        wdt_reg;
    logic [PRESC_W-1:0]      presc_reg;
    logic                    ack_reg;
    logic [31:0]             rdata_reg;
    logic                    wake_meta_reg;
    logic                    wake_sync_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic                    bus_req;
    logic                    bus_wr;
    logic [11:0]             off;
    logic                    is_mem;
    logic [MEM_ADDR_W-1:0]   mem_idx;
    logic                    issue;
    logic [3:0]              op;
    logic [2:0]              bitsel;
    logic [MEM_ADDR_W-1:0]   maddr;
    logic [7:0]              mval;
    logic [7:0]              alu_res;
    logic                    alu_c;
    logic                    wdt_clr;
    logic                    wdt_tick;
    logic                    mem_wr_exec;
    logic                    acc_wr_exec;

    assign bus_req  = cyc_i && stb_i;
    assign bus_wr   = bus_req && we_i && ack_reg;
    assign off      = {adr_i[11:2], 2'b00};
    assign is_mem   = adr_i[11:9] == MEM_BASE_OFF[11:9];
    assign mem_idx  = adr_i[MEM_ADDR_W+1:2];
    assign issue    = bus_wr && off == CMD_OFF && sel_i[0] && state_reg == ST_RUN;
    assign op       = dat_i[CMD_OP_LSB +: 4];
    assign bitsel   = dat_i[CMD_BIT_LSB +: 3];
    assign maddr    = dat_i[CMD_ADDR_LSB +: MEM_ADDR_W];
    assign mval     = mem_reg[maddr];
    assign ack_o    = ack_reg;
    assign dat_o    = rdata_reg;
    assign sleep_o  = sleep_reg;
    assign timeout_o = to_reg;

    assign mem_wr_exec = issue && (op == OP_CLEAR_MEM || op == OP_CLEAR_BIT || op == OP_INVERT_MEM
                                   || op == OP_BCD_ADJUST || op == OP_DEC_MEM || op == OP_INC_MEM);
    assign acc_wr_exec = issue && (op == OP_INVERT_ACC || op == OP_DEC_ACC);

    exec_alu u_alu (
        .op_i     (op),
        .bit_i    (bitsel),
        .mem_i    ((op == OP_BCD_ADJUST) ? acc_reg : mval),
        .acc_i    (acc_reg),
        .c_i      (c_reg),
        .ac_i     (ac_reg),
        .result_o (alu_res),
        .c_o      (alu_c)
    );

    // ------------------------------------------------------------
    // wake pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else if (ce_i) begin
            wake_meta_reg <= wake_i;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg   <= bus_req && !ack_reg;
            rdata_reg <= 32'h0000_0000;
            if (bus_req && !ack_reg && !we_i) begin
                if (is_mem) begin
                    rdata_reg <= {24'h000000, mem_reg[mem_idx]};
                end else begin
                    unique case (off)
                        ACC_OFF:   rdata_reg <= {24'h000000, acc_reg};
                        FLAGS_OFF: rdata_reg <= {26'h0000000, state_reg != ST_RUN, sleep_reg,
                                                 to_reg, ac_reg, c_reg, z_reg};
                        PC_OFF:    rdata_reg <= {21'h000000, pc_reg};
                        SP_OFF:    rdata_reg <= {29'h00000000, sp_reg};
                        WDT_OFF:   rdata_reg <= {24'h000000, wdt_reg};
                        default:   rdata_reg <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sequencing: call second cycle and power down
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RUN;
            tgt_reg   <= PC_RST;
        end else if (ce_i) begin
            unique case (state_reg)
                ST_RUN: begin
                    if (issue && op == OP_CALL) begin
                        state_reg <= ST_CALL2;
                        tgt_reg   <= dat_i[CMD_TGT_LSB +: PC_W];
                    end else if (issue && op == OP_POWER_DOWN) begin
                        state_reg <= ST_SLEEP;
                    end
                end
                ST_CALL2: state_reg <= ST_RUN;
                ST_SLEEP: if (wake_sync_reg) state_reg <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // program counter and stack
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= PC_RST;
            sp_reg <= '0;
        end else if (ce_i) begin
            if (issue && op == OP_CALL) begin
                stack_reg[sp_reg] <= pc_reg + 11'h001;
                sp_reg            <= sp_reg + 3'h1;
            end else if (state_reg == ST_CALL2) begin
                pc_reg <= tgt_reg;
            end else if (issue) begin
                pc_reg <= pc_reg + 11'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // data memory
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (mem_wr_exec) begin
                mem_reg[maddr] <= alu_res;
            end else if (bus_wr && is_mem && sel_i[0] && state_reg != ST_SLEEP) begin
                mem_reg[mem_idx] <= dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and arithmetic flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= ACC_RST;
            z_reg   <= 1'b0;
            c_reg   <= 1'b0;
            ac_reg  <= 1'b0;
        end else if (ce_i) begin
            if (acc_wr_exec) begin
                acc_reg <= alu_res;
                z_reg   <= alu_res == 8'h00;
            end else if (issue && (op == OP_DEC_MEM || op == OP_INC_MEM)) begin
                z_reg   <= alu_res == 8'h00;
            end else if (issue && op == OP_BCD_ADJUST) begin
                c_reg   <= alu_c;
            end else if (bus_wr && state_reg == ST_RUN && sel_i[0]) begin
                if (off == ACC_OFF) acc_reg <= dat_i[7:0];
                if (off == FLAGS_OFF) begin
                    z_reg  <= dat_i[FLG_Z];
                    c_reg  <= dat_i[FLG_C];
                    ac_reg <= dat_i[FLG_AC];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog, pairing and status flags
    // ------------------------------------------------------------
    assign wdt_clr = issue && (op == OP_WDT_CLEAR
                     || (op == OP_WDT_FIRST && half_reg == HALF_SECOND)
                     || (op == OP_WDT_SECOND && half_reg == HALF_FIRST));
    assign wdt_tick = state_reg != ST_SLEEP && presc_reg == '1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_reg <= HALF_NONE;
        end else if (ce_i && issue) begin
            if (wdt_clr && op != OP_WDT_CLEAR) half_reg <= HALF_NONE;
            else if (op == OP_WDT_FIRST) half_reg <= HALF_FIRST;
            else if (op == OP_WDT_SECOND) half_reg <= HALF_SECOND;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_reg   <= '0;
            presc_reg <= '0;
            to_reg    <= 1'b0;
            sleep_reg <= 1'b0;
        end else if (ce_i) begin
            if (issue && op == OP_POWER_DOWN) begin
                wdt_reg   <= '0;
                presc_reg <= '0;
                sleep_reg <= 1'b1;
                to_reg    <= 1'b0;
            end else if (wdt_clr) begin
                wdt_reg   <= '0;
                presc_reg <= '0;
                to_reg    <= 1'b0;
                sleep_reg <= 1'b0;
            end else if (state_reg != ST_SLEEP) begin
                presc_reg <= presc_reg + 8'h01;
                if (wdt_tick) begin
                    wdt_reg <= wdt_reg + 8'h01;
                    if (wdt_reg == '1) to_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_call_push;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_CALL) |=> stack_reg[$past(sp_reg)] == $past(pc_reg) + 11'h001;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call did not push pc plus one");

    property p_call_two;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_CALL) ##1 ce_i |=> state_reg == ST_RUN && pc_reg == $past(tgt_reg);
    endproperty
    a_call_two: assert property (p_call_two) else $error("call target not loaded on second cycle");

    property p_call_flags;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_CALL) |=> $stable(z_reg) && $stable(c_reg) && $stable(ac_reg);
    endproperty
    a_call_flags: assert property (p_call_flags) else $error("call changed a flag");

    property p_clear_mem;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_CLEAR_MEM) |=> mem_reg[$past(maddr)] == 8'h00 && $stable(z_reg);
    endproperty
    a_clear_mem: assert property (p_clear_mem) else $error("clear memory failed");

    property p_wdt_repeat;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_WDT_FIRST && half_reg == HALF_FIRST) |-> !wdt_clr;
    endproperty
    a_wdt_repeat: assert property (p_wdt_repeat) else $error("repeated half cleared watchdog");

    property p_wdt_pair;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_WDT_SECOND && half_reg == HALF_FIRST)
            |=> wdt_reg == 8'h00 && !to_reg && !sleep_reg;
    endproperty
    a_wdt_pair: assert property (p_wdt_pair) else $error("paired clear had no effect");

    property p_wdt_full;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_WDT_CLEAR) |=> wdt_reg == 8'h00 && !to_reg && !sleep_reg;
    endproperty
    a_wdt_full: assert property (p_wdt_full) else $error("watchdog clear had no effect");

    property p_inv_acc;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_INVERT_ACC) |=> acc_reg == ~$past(mval) && z_reg == (acc_reg == 8'h00);
    endproperty
    a_inv_acc: assert property (p_inv_acc) else $error("invert to accumulator wrong");

    property p_dec_acc;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_DEC_ACC) |=> acc_reg == $past(mval) - 8'h01 && $stable(c_reg);
    endproperty
    a_dec_acc: assert property (p_dec_acc) else $error("decrement to accumulator wrong");

    property p_power_down;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && issue && op == OP_POWER_DOWN) |=> sleep_reg && !to_reg && wdt_reg == 8'h00 && state_reg == ST_SLEEP;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down entry wrong");

    property p_sleep_hold;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && state_reg == ST_SLEEP) |=> $stable(acc_reg) && $stable(pc_reg);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("state changed while asleep");
endmodule
`default_nettype wire

// ==== exec_pkg.sv ====
// constants, opcodes and register map of the instruction execute block
package exec_pkg;
    // ------------------------------------------------------------
    // widths and storage
    // ------------------------------------------------------------
    localparam int unsigned PC_W        = 11;
    localparam int unsigned MEM_ADDR_W  = 7;
    localparam int unsigned MEM_DEPTH   = 128;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned SP_W        = 3;
    localparam int unsigned WDT_W       = 8;
    localparam int unsigned PRESC_W     = 8;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] CMD_OFF      = 12'h000;
    localparam logic [11:0] ACC_OFF      = 12'h004;
    localparam logic [11:0] FLAGS_OFF    = 12'h008;
    localparam logic [11:0] PC_OFF       = 12'h00c;
    localparam logic [11:0] SP_OFF       = 12'h010;
    localparam logic [11:0] WDT_OFF      = 12'h014;
    localparam logic [11:0] MEM_BASE_OFF = 12'h200;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int unsigned CMD_OP_LSB   = 0;
    localparam int unsigned CMD_BIT_LSB  = 4;
    localparam int unsigned CMD_ADDR_LSB = 8;
    localparam int unsigned CMD_TGT_LSB  = 16;
    localparam int unsigned FLG_Z        = 0;
    localparam int unsigned FLG_C        = 1;
    localparam int unsigned FLG_AC       = 2;
    localparam int unsigned FLG_TO       = 3;
    localparam int unsigned FLG_SLEEP    = 4;
    localparam int unsigned FLG_BUSY     = 5;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]      ACC_RST   = 8'h00;
    localparam logic [PC_W-1:0] PC_RST    = 11'h000;
    localparam logic [7:0]      BCD_NINE  = 8'h09;
    localparam logic [7:0]      BCD_LO6   = 8'h06;
    localparam logic [7:0]      BCD_HI6   = 8'h60;
    localparam int unsigned     CALL_CYCLES = 2;

    typedef enum logic [3:0] {
        OP_NOP, OP_CALL, OP_CLEAR_MEM, OP_CLEAR_BIT, OP_WDT_CLEAR,
        OP_WDT_FIRST, OP_WDT_SECOND, OP_INVERT_MEM, OP_INVERT_ACC,
        OP_BCD_ADJUST, OP_DEC_MEM, OP_DEC_ACC, OP_INC_MEM, OP_POWER_DOWN
    } op_t;
endpackage

// ==== exec_alu.sv ====
// data path of the memory and accumulator instructions
`timescale 1ns/1ps
`default_nettype none
module exec_alu
    import exec_pkg::*;
(
    input  wire logic [3:0] op_i,
    input  wire logic [2:0] bit_i,
    input  wire logic [7:0] mem_i,
    input  wire logic [7:0] acc_i,
    input  wire logic       c_i,
    input  wire logic       ac_i,
    output logic      [7:0] result_o,
    output logic            c_o
);
    logic       lo_fix;
    logic       hi_fix;
    logic [8:0] bcd_sum;

    always_comb begin
        lo_fix  = ({4'h0, acc_i[3:0]} > BCD_NINE) || ac_i;
        hi_fix  = ({4'h0, acc_i[7:4]} > BCD_NINE) || c_i;
        bcd_sum = {1'b0, acc_i} + {1'b0, (hi_fix ? BCD_HI6 : 8'h00) | (lo_fix ? BCD_LO6 : 8'h00)};
        result_o = mem_i;
        c_o      = c_i;
        unique case (op_i)
            OP_CLEAR_MEM:  result_o = 8'h00;
            OP_CLEAR_BIT:  result_o = mem_i & ~(8'h01 << bit_i);
            OP_INVERT_MEM, OP_INVERT_ACC: result_o = ~mem_i;
            OP_BCD_ADJUST: begin
                result_o = bcd_sum[7:0];
                c_o      = c_i | bcd_sum[8];
            end
            OP_DEC_MEM, OP_DEC_ACC: result_o = mem_i - 8'h01;
            OP_INC_MEM:    result_o = mem_i + 8'h01;
            default:       result_o = mem_i;
        endcase
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench of the instruction execute unit
`timescale 1ns/1ps
`default_nettype none
module testbench
    import exec_pkg::*;
();
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        wake_i = 1'b0;
    logic        ce_i   = 1'b1;
    logic        cyc_i  = 1'b0;
    logic        stb_i  = 1'b0;
    logic        we_i   = 1'b0;
    logic [31:0] adr_i  = 32'h0;
    logic [31:0] dat_i  = 32'h0;
    logic [3:0]  sel_i  = 4'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        sleep_o;
    logic        timeout_o;
    logic [31:0] q;
    int          err_count   = 0;
    int          checks_done = 0;
    always #50 clk_i = ~clk_i;
    exec_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wake_i(wake_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .sleep_o(sleep_o), .timeout_o(timeout_o));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("[FAIL] bus ack expected 1 seen 0");
            close_out;
        end
        @(posedge clk_i);
    endtask
    function automatic logic [31:0] ra(input logic [11:0] off);
        return {20'h0, off};
    endfunction
    function automatic logic [31:0] ma(input logic [6:0] m);
        return {20'h0, MEM_BASE_OFF + {3'h0, m, 2'b00}};
    endfunction
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        check(nm, e, q);
    endtask
    task automatic cmd(input op_t op, input logic [2:0] b, input logic [6:0] m, input logic [10:0] t);
        wb(1'b1, ra(CMD_OFF), {5'h00, t, 1'b0, m, 1'b0, b, op});
    endtask
    task automatic mop(input op_t op, input logic [2:0] b, input logic [6:0] m, input logic [7:0] init,
                       input logic [7:0] acc, input logic [7:0] fl, input logic [7:0] mexp,
                       input logic [7:0] aexp, input logic [7:0] fexp);
        wb(1'b1, ma(m), {24'h0, init});
        wb(1'b1, ra(ACC_OFF), {24'h0, acc});
        wb(1'b1, ra(FLAGS_OFF), {24'h0, fl});
        cmd(op, b, m, 11'h000);
        rd(ma(m), {24'h0, mexp}, "memory byte");
        rd(ra(ACC_OFF), {24'h0, aexp}, "accumulator");
        rd(ra(FLAGS_OFF), {24'h0, fexp}, "flags");
    endtask
    task automatic pd_wake;
        cmd(OP_POWER_DOWN, 3'h0, 7'h00, 11'h000);
        wake_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wake_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_call;
        rd(ra(PC_OFF), 32'h0, "pc after reset");
        cmd(OP_NOP, 3'h0, 7'h00, 11'h000);
        rd(ra(PC_OFF), 32'h1, "pc after nop");
        wb(1'b1, ra(FLAGS_OFF), 32'h5);
        cmd(OP_CALL, 3'h0, 7'h00, 11'h123);
        rd(ra(PC_OFF), 32'h123, "pc after call");
        rd(ra(SP_OFF), 32'h1, "stack depth");
        rd(ra(FLAGS_OFF), 32'h5, "flags after call");
        cmd(OP_CALL, 3'h0, 7'h00, 11'h7ff);
        rd(ra(SP_OFF), 32'h2, "stack depth");
        cmd(OP_NOP, 3'h0, 7'h00, 11'h000);
        rd(ra(PC_OFF), 32'h0, "pc wrap after call");
    endtask
    task automatic t_mem;
        mop(OP_CLEAR_MEM, 3'h0, 7'h05, 8'h3c, 8'h33, 8'h07, 8'h00, 8'h33, 8'h07);
        mop(OP_CLEAR_BIT, 3'h3, 7'h06, 8'hff, 8'h33, 8'h00, 8'hf7, 8'h33, 8'h00);
        mop(OP_CLEAR_BIT, 3'h0, 7'h06, 8'h01, 8'h33, 8'h06, 8'h00, 8'h33, 8'h06);
        mop(OP_INVERT_MEM, 3'h0, 7'h07, 8'h5a, 8'h33, 8'h00, 8'ha5, 8'h33, 8'h00);
        mop(OP_INVERT_ACC, 3'h0, 7'h08, 8'hff, 8'h33, 8'h06, 8'hff, 8'h00, 8'h07);
        mop(OP_INVERT_ACC, 3'h0, 7'h08, 8'h0f, 8'h33, 8'h01, 8'h0f, 8'hf0, 8'h00);
        mop(OP_DEC_MEM, 3'h0, 7'h09, 8'h01, 8'h33, 8'h06, 8'h00, 8'h33, 8'h07);
        mop(OP_DEC_MEM, 3'h0, 7'h09, 8'h00, 8'h33, 8'h01, 8'hff, 8'h33, 8'h00);
        mop(OP_DEC_ACC, 3'h0, 7'h0a, 8'h00, 8'h33, 8'h01, 8'h00, 8'hff, 8'h00);
        mop(OP_DEC_ACC, 3'h0, 7'h0a, 8'h01, 8'h33, 8'h00, 8'h01, 8'h00, 8'h01);
        mop(OP_INC_MEM, 3'h0, 7'h0b, 8'hff, 8'h33, 8'h00, 8'h00, 8'h33, 8'h01);
        mop(OP_INC_MEM, 3'h0, 7'h0b, 8'h41, 8'h33, 8'h01, 8'h42, 8'h33, 8'h00);
    endtask
    task automatic t_bcd;
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'h12, 8'h00, 8'h12, 8'h12, 8'h00);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'h1a, 8'h01, 8'h20, 8'h1a, 8'h01);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'h12, 8'h04, 8'h18, 8'h12, 8'h04);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'ha2, 8'h00, 8'h02, 8'ha2, 8'h02);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'h99, 8'h02, 8'hf9, 8'h99, 8'h02);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'h9a, 8'h00, 8'ha0, 8'h9a, 8'h00);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'hff, 8'h05, 8'h65, 8'hff, 8'h07);
        mop(OP_BCD_ADJUST, 3'h0, 7'h0c, 8'h00, 8'h00, 8'h06, 8'h66, 8'h00, 8'h06);
    endtask
    task automatic t_sleep;
        int n;
        n = 0;
        while (timeout_o !== 1'b1 && n < 70000) begin
            @(posedge clk_i);
            n++;
        end
        check("timeout before sleep", 32'h1, {31'h0, timeout_o});
        if (timeout_o !== 1'b1) close_out;
        wb(1'b1, ma(7'h0d), 32'h81);
        wb(1'b1, ra(ACC_OFF), 32'h5c);
        wb(1'b1, ra(FLAGS_OFF), 32'h0);
        cmd(OP_POWER_DOWN, 3'h0, 7'h00, 11'h000);
        check("timeout flag", 32'h0, {31'h0, timeout_o});
        check("sleep flag", 32'h1, {31'h0, sleep_o});
        rd(ra(FLAGS_OFF), 32'h30, "flags asleep");
        rd(ra(WDT_OFF), 32'h0, "watchdog asleep");
        cmd(OP_INC_MEM, 3'h0, 7'h0d, 11'h000);
        rd(ma(7'h0d), 32'h81, "memory asleep");
        rd(ra(ACC_OFF), 32'h5c, "accumulator asleep");
        wake_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wake_i <= 1'b0;
        @(posedge clk_i);
        cmd(OP_INC_MEM, 3'h0, 7'h0d, 11'h000);
        rd(ma(7'h0d), 32'h82, "memory after wake");
    endtask
    task automatic t_wdt;
        cmd(OP_WDT_FIRST, 3'h0, 7'h00, 11'h000);
        check("sleep one half", 32'h1, {31'h0, sleep_o});
        cmd(OP_WDT_FIRST, 3'h0, 7'h00, 11'h000);
        check("sleep same half", 32'h1, {31'h0, sleep_o});
        cmd(OP_WDT_SECOND, 3'h0, 7'h00, 11'h000);
        check("sleep pair", 32'h0, {31'h0, sleep_o});
        pd_wake();
        cmd(OP_WDT_SECOND, 3'h0, 7'h00, 11'h000);
        cmd(OP_WDT_SECOND, 3'h0, 7'h00, 11'h000);
        check("sleep same half", 32'h1, {31'h0, sleep_o});
        cmd(OP_WDT_FIRST, 3'h0, 7'h00, 11'h000);
        check("sleep pair", 32'h0, {31'h0, sleep_o});
        pd_wake();
        cmd(OP_WDT_CLEAR, 3'h0, 7'h00, 11'h000);
        check("sleep full clear", 32'h0, {31'h0, sleep_o});
        rd(ra(FLAGS_OFF), 32'h0, "flags full clear");
    endtask
    task automatic t_ce;
        int n;
        n = 0;
        ce_i  <= 1'b0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= 1'b1;
        adr_i <= ra(ACC_OFF);
        dat_i <= 32'hc5;
        sel_i <= 4'hf;
        repeat (4) @(posedge clk_i);
        check("ack while frozen", 32'h0, {31'h0, ack_o});
        ce_i <= 1'b1;
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check("ack after freeze", 32'h1, {31'h0, ack_o});
        if (ack_o !== 1'b1) close_out;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
        rd(ra(ACC_OFF), 32'hc5, "accumulator after freeze");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_call();
        t_mem();
        t_bcd();
        t_sleep();
        t_wdt();
        t_ce();
        close_out();
    end
endmodule
`default_nettype wire
